// file: hdl/pps_pkg.sv
/*
 Constants for the port priority shutdown pair: register indexes, field positions,
 reset values and timing counts. Assumes a 125 MHz mclk on both ends.
*/
package pps_pkg;
   localparam int NPORT = 4;
   // ****************************************
   // Register indexes; byte address is four times the index.
   // ****************************************
   localparam logic [5:0] REG_INT = 6'h00;
   localparam logic [5:0] REG_SUP_A = 6'h0a;
   localparam logic [5:0] REG_SUP_B = 6'h0b;
   localparam logic [5:0] REG_PWR = 6'h10;
   localparam logic [5:0] REG_PROBE = 6'h14;
   localparam logic [5:0] REG_PRIO_MASK = 6'h15;
   localparam logic [5:0] REG_OPT = 6'h17;
   localparam logic [5:0] REG_PRIO_LO = 6'h27;
   localparam logic [5:0] REG_PRIO_HI = 6'h28;
   localparam logic [5:0] REG_OPMODE = 6'h30;
   localparam int OPT_MULTI_BIT = 4;
   localparam int SUP_SHED_BIT = 1;
   localparam int INT_SUPPLY_BIT = 7;
   localparam int LOWPRI_LSB = 4;
   localparam int PAIR_LSB = 2;
   localparam logic [1:0] MODE_SEMI = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h1;
   localparam logic [1:0] MODE_CTRL = 2'h2;
   localparam logic [7:0] PROBE_RST = 8'h0f;
   localparam logic [7:0] OPMODE_RST = 8'h01;
   localparam logic [3:0] CLASS_2P_MAX = 4'h4;
   localparam logic [3:0] CLASS_4P_MIN = 4'h5;
   localparam logic [3:0] CLASS_4P_MAX = 4'h8;
   // ****************************************
   // Timing.
   // ****************************************
   localparam int CLK_MHZ = 125;
   localparam int BIT_TYP_NS = 25000;
   localparam int BIT_MIN_NS = 24000;
   localparam int BIT_MAX_NS = 26000;
   localparam int OFF_MIN_NS = 1000;
   localparam int GAP_NS = 50000;
   localparam int REBUILD_NS = 3000000;
   localparam int BIT_CYC = BIT_TYP_NS * CLK_MHZ / 1000;
   localparam int BIT_MIN_CYC = (BIT_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int BIT_MAX_CYC = BIT_MAX_NS * CLK_MHZ / 1000;
   localparam int HALF_CYC = BIT_CYC / 2;
   localparam int OFF_CYC = (OFF_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC = GAP_NS * CLK_MHZ / 1000;
   localparam int REBUILD_CYC = REBUILD_NS * CLK_MHZ / 1000;
   localparam int CNT_W = 13;
endpackage

// file: hdl/pps_link_if.sv
/*
 Shed line between the host end and the device end.
 Assumes both ends share mclk; the device still synchronises the line.
*/
`timescale 1ns/1ps
interface pps_link_if;
   logic load_shed_input;
   modport host (output load_shed_input);
   modport dev (input load_shed_input);
endinterface

// file: hdl/pps_shed_host.sv
/*
 Host end: drives the shed line as a level or as framed 3-bit codes.
 Assumes the user holds code_valid until code_ready.
*/
`timescale 1ns/1ps
module pps_shed_host #(
   parameter int GAP_CYC = pps_pkg::GAP_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   pps_link_if.host link,
   input wire logic multi_mode,
   input wire logic shed_level,
   input wire logic code_valid,
   output logic code_ready,
   input wire logic [2:0] code,
   output logic busy
);
   // The one counter times both the bit periods and the gap, so it is sized for the longer.
   localparam int GW = $clog2((GAP_CYC > pps_pkg::BIT_CYC ? GAP_CYC : pps_pkg::BIT_CYC) + 1);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_GAP} pps_host_e;
   pps_host_e st_q;
   logic [GW-1:0] cnt_q;
   logic [1:0] idx_q;
   logic [2:0] code_q;
   logic out_q;

   assign code_ready = multi_mode && st_q == H_IDLE;
   assign busy = st_q != H_IDLE;
   assign link.load_shed_input = out_q;

   // ****************************************
   // Framing: start bit, three code bits, idle gap.
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_q <= H_IDLE;
         cnt_q <= '0;
         idx_q <= 2'h0;
         code_q <= 3'h0;
         out_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;
         case (st_q)
            H_IDLE:
            begin
               cnt_q <= '0;
               out_q <= multi_mode ? 1'b0 : shed_level;
               if (code_valid && code_ready)
               begin
                  code_q <= code;
                  out_q <= 1'b1;
                  st_q <= H_START;
               end
            end
            H_START:
            begin
               // The start bit is high for its first half and low for its second, so
               // the line always returns low before the first code bit.
               if (cnt_q == GW'(pps_pkg::HALF_CYC - 1))
                  out_q <= 1'b0;
               if (cnt_q == GW'(pps_pkg::BIT_CYC - 1))
               begin
                  cnt_q <= '0;
                  idx_q <= 2'h0;
                  out_q <= code_q[2];
                  code_q <= {code_q[1:0], 1'b0};
                  st_q <= H_BITS;
               end
            end
            H_BITS:
               if (cnt_q == GW'(pps_pkg::BIT_CYC - 1))
               begin
                  cnt_q <= '0;
                  idx_q <= idx_q + 1'b1;
                  out_q <= code_q[2];
                  code_q <= {code_q[1:0], 1'b0};
                  if (idx_q == 2'h2)
                  begin
                     out_q <= 1'b0;
                     st_q <= H_GAP;
                  end
               end
            H_GAP:
               if (cnt_q == GW'(GAP_CYC - 1))
                  st_q <= H_IDLE;
            default:
               st_q <= H_IDLE;
         endcase
      end
   end
endmodule

// file: hdl/pps_shed_dev.sv
/*
 Device end: priority shutdown of four ports with 2-pair/4-pair power gating.
 Assumes an Avalon-MM master on the register side and the shed line on the link.
*/
`timescale 1ns/1ps
module pps_shed_dev #(
   parameter int REBUILD_CYC = pps_pkg::REBUILD_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   pps_link_if.dev link,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] power_request,
   input wire logic [15:0] port_class,
   input wire logic [3:0] power_good,
   input wire logic peer_multi_bit,
   output logic multi_bit_sel,
   output logic [3:0] port_power_en,
   output logic [3:0] probe_allow
);
   localparam int CW = pps_pkg::CNT_W;
   localparam int RW = $clog2(REBUILD_CYC + 1);
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DROP, RX_BITS, RX_OFF} pps_rx_e;

   logic [2:0] sync_q;
   logic lvl_q, rise, fall;
   logic ack_q, wr_go, rd_go;
   logic [5:0] idx;
   logic [7:0] rd_val;
   logic [7:0] probe_q, mask_q, opt_q, prio_lo_q, prio_hi_q, opmode_q;
   logic int_q, sup_a_q, sup_b_q;
   logic multi, evt, apply;
   logic [1:0] mode;
   pps_rx_e rx_q;
   logic [CW-1:0] cnt_q;
   logic [1:0] bit_q;
   logic [2:0] code_q;
   logic [RW-1:0] reb_q;
   logic [11:0] tbl_prio_q;
   logic [3:0] tbl_low_q, held_q, on_q, kill, elig, ok;
   logic [11:0] prio_src;

   assign mode = opmode_q[1:0];
   assign multi_bit_sel = opt_q[pps_pkg::OPT_MULTI_BIT];
   assign multi = multi_bit_sel | peer_multi_bit;
   assign port_power_en = on_q;
   assign probe_allow = probe_q[3:0] & ~held_q;

   // ****************************************
   // Shed line synchroniser; a level counts once stages two and three agree.
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (rst)
         sync_q <= 3'h0;
      else
         sync_q <= {sync_q[1:0], link.load_shed_input};
   end

   assign rise = !lvl_q && sync_q[1] && sync_q[2];
   assign fall = lvl_q && !sync_q[1] && !sync_q[2];

   always_ff @(posedge mclk)
   begin
      if (rst)
         lvl_q <= 1'b0;
      else if (sync_q[1] == sync_q[2])
         lvl_q <= sync_q[2];
   end

   // ****************************************
   // Avalon slave: one wait cycle, then the answer.
   // ****************************************
   assign idx = avs_address[7:2];
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_go = avs_write && ack_q && avs_byteenable[0];
   assign rd_go = avs_read && ack_q;

   always_ff @(posedge mclk)
   begin
      if (rst)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read || avs_write) && !ack_q;
   end

   always_comb
   begin
      rd_val = 8'h00;
      case (idx)
         pps_pkg::REG_INT: rd_val[pps_pkg::INT_SUPPLY_BIT] = int_q;
         pps_pkg::REG_SUP_A: rd_val[pps_pkg::SUP_SHED_BIT] = sup_a_q;
         pps_pkg::REG_SUP_B: rd_val[pps_pkg::SUP_SHED_BIT] = sup_b_q;
         pps_pkg::REG_PWR: rd_val = {power_good & on_q, on_q};
         pps_pkg::REG_PROBE: rd_val = probe_q;
         pps_pkg::REG_PRIO_MASK: rd_val = mask_q;
         pps_pkg::REG_OPT: rd_val = opt_q;
         pps_pkg::REG_PRIO_LO: rd_val = prio_lo_q;
         pps_pkg::REG_PRIO_HI: rd_val = prio_hi_q;
         pps_pkg::REG_OPMODE: rd_val = opmode_q;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         avs_readdata <= 32'h0;
      else if (avs_read && !ack_q)
         avs_readdata <= {24'h0, rd_val};
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mask_q <= 8'h00;
         opt_q <= 8'h00;
         prio_lo_q <= 8'h00;
         prio_hi_q <= 8'h00;
         opmode_q <= pps_pkg::OPMODE_RST;
      end
      else if (wr_go)
      begin
         if (idx == pps_pkg::REG_PRIO_MASK) mask_q <= avs_writedata[7:0];
         if (idx == pps_pkg::REG_OPT) opt_q <= avs_writedata[7:0];
         if (idx == pps_pkg::REG_PRIO_LO) prio_lo_q <= avs_writedata[7:0];
         if (idx == pps_pkg::REG_PRIO_HI) prio_hi_q <= avs_writedata[7:0];
         if (idx == pps_pkg::REG_OPMODE) opmode_q <= avs_writedata[7:0];
      end
   end

   // In semi-auto mode a single-bit shed drops the probe enables of the
   // ports it held; only a host write brings them back.
   always_ff @(posedge mclk)
   begin
      if (rst)
         probe_q <= pps_pkg::PROBE_RST;
      else if (wr_go && idx == pps_pkg::REG_PROBE)
         probe_q <= avs_writedata[7:0];
      else if (evt && !multi && mode == pps_pkg::MODE_SEMI)
         probe_q[3:0] <= probe_q[3:0] & ~tbl_low_q;
   end

   // ****************************************
   // Event flags, cleared by reading their register; a new event wins.
   // ****************************************
   assign evt = multi ? apply : rise;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         int_q <= 1'b0;
         sup_a_q <= 1'b0;
         sup_b_q <= 1'b0;
      end
      else if (evt)
      begin
         int_q <= 1'b1;
         sup_a_q <= 1'b1;
         sup_b_q <= 1'b1;
      end
      else if (rd_go)
      begin
         if (idx == pps_pkg::REG_INT) int_q <= 1'b0;
         if (idx == pps_pkg::REG_SUP_A) sup_a_q <= 1'b0;
         if (idx == pps_pkg::REG_SUP_B) sup_b_q <= 1'b0;
      end
   end

   // ****************************************
   // Multi-bit code receiver.
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (rst || !multi)
      begin
         rx_q <= RX_IDLE;
         cnt_q <= '0;
         bit_q <= 2'h0;
         code_q <= 3'h0;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;
         case (rx_q)
            RX_IDLE:
            begin
               cnt_q <= '0;
               if (rise) rx_q <= RX_START;
            end
            RX_START:
               if (fall)
               begin
                  cnt_q <= '0;
                  bit_q <= 2'h0;
                  // The start bit is high for half a bit period.
                  if (cnt_q >= CW'(pps_pkg::BIT_MIN_CYC / 2)) rx_q <= RX_BITS;
                  else rx_q <= RX_IDLE;
               end
               else if (cnt_q > CW'(pps_pkg::BIT_MAX_CYC / 2))
                  rx_q <= RX_DROP;
            RX_DROP:
               if (fall) rx_q <= RX_IDLE;
            RX_BITS:
            begin
               // The start fall lies mid-bit, so each full period after it is a bit middle.
               if (cnt_q == CW'(pps_pkg::BIT_CYC - 1))
               begin
                  code_q <= {code_q[1:0], lvl_q};
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == 2'h2)
                  begin
                     cnt_q <= '0;
                     rx_q <= RX_OFF;
                  end
               end
               if (cnt_q == CW'(pps_pkg::BIT_CYC - 1)) cnt_q <= '0;
            end
            RX_OFF:
               if (cnt_q == CW'(pps_pkg::OFF_CYC - 1)) rx_q <= RX_IDLE;
            default:
               rx_q <= RX_IDLE;
         endcase
      end
   end

   assign apply = rx_q == RX_OFF && cnt_q == CW'(pps_pkg::OFF_CYC - 1);

   // ****************************************
   // Priority table: periodic snapshot, held still during a shed event.
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         reb_q <= '0;
         tbl_prio_q <= 12'h000;
         tbl_low_q <= 4'h0;
      end
      else
      begin
         reb_q <= reb_q + 1'b1;
         if (reb_q == RW'(REBUILD_CYC - 1))
         begin
            reb_q <= '0;
            if (rx_q == RX_IDLE && !lvl_q)
            begin
               tbl_prio_q <= prio_src;
               tbl_low_q <= mask_q[pps_pkg::LOWPRI_LSB +: pps_pkg::NPORT];
            end
         end
      end
   end

   // ****************************************
   // Per-port power gating, shed kill and hold.
   // ****************************************
   for (genvar i = 0; i < pps_pkg::NPORT; i++)
   begin : g_port
      localparam int P = i ^ 1;
      logic [3:0] cls;
      logic lnk;
      assign prio_src[3*i +: 3] = i < 2 ? prio_lo_q[4*(i%2) +: 3] : prio_hi_q[4*(i%2) +: 3];
      assign cls = port_class[4*i +: 4];
      assign lnk = opmode_q[pps_pkg::PAIR_LSB + i/2];
      assign elig[i] = power_request[i] && probe_allow[i] &&
         (lnk ? (cls >= pps_pkg::CLASS_4P_MIN && cls <= pps_pkg::CLASS_4P_MAX)
              : (cls <= pps_pkg::CLASS_2P_MAX));
      assign ok[i] = elig[i] && (!lnk || elig[P]);
      assign kill[i] = (rise && !multi && tbl_low_q[i]) ||
         (apply && tbl_prio_q[3*i +: 3] <= code_q);

      always_ff @(posedge mclk)
      begin
         if (rst)
            on_q[i] <= 1'b0;
         else
            on_q[i] <= ok[i] && !kill[i];
      end

      always_ff @(posedge mclk)
      begin
         if (rst || multi)
            held_q[i] <= 1'b0;
         else if (rise && tbl_low_q[i])
            held_q[i] <= 1'b1;
         else if (!lvl_q && (mode != pps_pkg::MODE_CTRL || probe_q[i]))
            held_q[i] <= 1'b0;
      end
   end
endmodule

// file: sim/pps_link_chk.sv
/*
 Checker for the shed line and the host end's user side.
 Assumes the bench instantiates it beside the interface, all on mclk.
*/
`timescale 1ns/1ps
module pps_link_chk #(
   parameter int GAP_CYC = pps_pkg::GAP_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load_shed_input,
   input wire logic multi_mode,
   input wire logic shed_level,
   input wire logic code_valid,
   input wire logic code_ready,
   input wire logic [2:0] code,
   input wire logic busy
);
   localparam int BC = pps_pkg::BIT_CYC;
   localparam int HC = pps_pkg::HALF_CYC;
   logic line_q;
   logic [14:0] run_q;
   logic [14:0] fc_q;
   logic [2:0] cap_q;
   // ****************************************
   // Run length and frame position.
   // ****************************************
   always_ff @(posedge mclk)
   begin
      line_q <= load_shed_input;
   end
   always_ff @(posedge mclk)
   begin
      if (rst || load_shed_input != line_q)
         run_q <= 15'h1;
      else if (run_q != 15'h7fff)
         run_q <= run_q + 15'h1;
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
         fc_q <= 15'h7fff;
      else if (code_valid && code_ready)
         fc_q <= 15'h0;
      else if (fc_q != 15'h7fff)
         fc_q <= fc_q + 15'h1;
   end
   always_ff @(posedge mclk)
   begin
      if (code_valid && code_ready)
         cap_q <= code;
   end
   // ****************************************
   // Properties.
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_idle_rst;
      $fell(rst) |-> !load_shed_input;
   endproperty
   a_idle_rst: assert property (p_idle_rst) else $error("line not idle low");
   property p_single;
      !multi_mode && !$past(multi_mode) && !$past(rst) |-> load_shed_input == $past(shed_level);
   endproperty
   a_single: assert property (p_single) else $error("line does not follow level");
   property p_start;
      code_valid && code_ready |=> load_shed_input [*8];
   endproperty
   a_start: assert property (p_start) else $error("start bit missing");
   property p_start_mid;
      fc_q == HC / 2 |-> load_shed_input;
   endproperty
   a_start_mid: assert property (p_start_mid) else $error("start bit short");
   property p_start_low;
      fc_q == HC + HC / 2 |-> !load_shed_input;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not back low");
   property p_busy;
      code_valid && code_ready |=> busy && !code_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("host not busy after accept");
   property p_bits;
      fc_q >= BC && fc_q < 4 * BC && (fc_q % BC) == HC |-> load_shed_input == cap_q[3 - fc_q / BC];
   endproperty
   a_bits: assert property (p_bits) else $error("code bit wrong");
   property p_end;
      fc_q == 4 * BC + HC |-> !load_shed_input;
   endproperty
   a_end: assert property (p_end) else $error("line not idle after code");
   property p_gap;
      fc_q < 4 * BC + GAP_CYC - 2 |-> !code_ready;
   endproperty
   a_gap: assert property (p_gap) else $error("new code before gap");
   property p_bit_len;
      multi_mode && line_q && !load_shed_input |-> run_q >= pps_pkg::BIT_MIN_CYC / 2
         && run_q <= 3 * pps_pkg::BIT_MAX_CYC;
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("high run length wrong");
endmodule

// file: sim/tb.sv
/*
 Bench for the shed pair: registers over Avalon-MM, shed line through the host end.
 Assumes the design and checker files are compiled first.
*/
`timescale 1ns/1ps
module tb;
   localparam int GAP = 200;
   localparam int BC = pps_pkg::BIT_CYC;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic multi_mode = 1'b0;
   logic shed_level = 1'b0;
   logic code_valid = 1'b0;
   logic [2:0] code = 3'h0;
   logic code_ready;
   logic busy;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] power_request = 4'h0;
   logic [15:0] port_class = 16'h0;
   logic [3:0] power_good = 4'h0;
   logic peer_multi_bit = 1'b0;
   logic multi_bit_sel;
   logic [3:0] port_power_en;
   logic [3:0] probe_allow;
   logic [31:0] seed = 32'h25;
   logic [2:0] pr [4];
   int n_errors = 0;
   int num_checks = 0;
   int cyc_cnt = 0;
   always #4 mclk = ~mclk;
   pps_link_if u_pps_link_if ();
   pps_shed_host #(.GAP_CYC(GAP)) u_pps_shed_host (.mclk(mclk), .rst(rst),
      .link(u_pps_link_if.host), .multi_mode(multi_mode), .shed_level(shed_level),
      .code_valid(code_valid), .code_ready(code_ready), .code(code), .busy(busy));
   pps_shed_dev #(.REBUILD_CYC(50)) u_pps_shed_dev (.mclk(mclk), .rst(rst),
      .link(u_pps_link_if.dev), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .power_request(power_request), .port_class(port_class), .power_good(power_good),
      .peer_multi_bit(peer_multi_bit), .multi_bit_sel(multi_bit_sel),
      .port_power_en(port_power_en), .probe_allow(probe_allow));
   pps_link_chk #(.GAP_CYC(GAP)) u_pps_link_chk (.mclk(mclk), .rst(rst),
      .load_shed_input(u_pps_link_if.load_shed_input), .multi_mode(multi_mode),
      .shed_level(shed_level), .code_valid(code_valid), .code_ready(code_ready),
      .code(code), .busy(busy));
   // ****************************************
   // Helpers.
   // ****************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [3:0] exp_pwr(input logic [1:0] lk, input logic [3:0] rq);
      logic [3:0] e;
      logic [3:0] c;
      for (int i = 0; i < 4; i++)
      begin
         c = port_class[4*i +: 4];
         e[i] = rq[i] && (lk[i/2] ? (c >= 4'h5 && c <= 4'h8) : c <= 4'h4);
      end
      for (int j = 0; j < 2; j++)
         if (lk[j]) e[2*j +: 2] = {2{e[2*j] && e[2*j+1]}};
      return e;
   endfunction
   task finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_rng(input int t, input int lo, input int hi);
      num_checks++;
      if (t < lo || t > hi)
      begin
         n_errors++;
         $display("MISMATCH %0t delay %0d", $time, t);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, wd};
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   task wr(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task rdc(input logic [5:0] idx, input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      chk(r, e);
   endtask
   task frame(input logic [2:0] c);
      logic [3:0] pw;
      logic [3:0] dr;
      logic [3:0] ex;
      int t;
      int td;
      code <= c;
      code_valid <= 1'b1;
      t = 0;
      do
      begin
         @(posedge mclk);
         t++;
      end while (code_ready !== 1'b1 && t < 100);
      code_valid <= 1'b0;
      pw = port_power_en;
      dr = 4'h0;
      td = 0;
      t = 0;
      while (t < 4 * BC + GAP + 20 && !(t > 100 && busy === 1'b0))
      begin
         @(posedge mclk);
         t++;
         if (td == 0 && (pw & ~port_power_en) != 4'h0) td = t;
         dr = dr | (pw & ~port_power_en);
      end
      chk({7'h0, busy}, 8'h00);
      for (int i = 0; i < 4; i++) ex[i] = pw[i] && pr[i] <= c;
      chk({4'h0, dr}, {4'h0, ex});
      if (ex != 4'h0) chk_rng(td, 4 * BC - pps_pkg::HALF_CYC + pps_pkg::OFF_CYC,
         4 * BC - pps_pkg::HALF_CYC + 50 * pps_pkg::CLK_MHZ + 8);
      rdc(6'h0a, 8'h02);
      rdc(6'h00, 8'h80);
      chk({4'h0, port_power_en}, {4'h0, pw});
   endtask
   always @(posedge mclk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 100000)
      begin
         n_errors++;
         $display("MISMATCH %0t timeout", $time);
         finish_test();
      end
   end
   // ****************************************
   // Scenarios.
   // ****************************************
   initial
   begin
      logic [31:0] p;
      logic [1:0] lk;
      cyc(2);
      rst <= 1'b0;
      rdc(6'h14, 8'h0f);
      rdc(6'h15, 8'h00);
      rdc(6'h17, 8'h00);
      wr(6'h3f, 8'hff);
      rdc(6'h3f, 8'h00);
      chk({7'h0, multi_bit_sel}, 8'h00);
      power_good <= 4'hf;
      repeat (6)
      begin
         p = xs();
         lk = p[1:0];
         power_request <= p[7:4];
         for (int i = 0; i < 4; i++) port_class[4*i +: 4] <= 4'(xs() % 9);
         wr(6'h30, {4'h0, lk, 2'b01});
         cyc(4);
         chk({4'h0, port_power_en}, {4'h0, exp_pwr(lk, power_request)});
      end
      wr(6'h30, 8'h01);
      for (int i = 0; i < 4; i++) port_class[4*i +: 4] <= 4'(xs() % 5);
      power_request <= 4'hf;
      wr(6'h15, 8'h50);
      cyc(60);
      for (int m = 0; m < 3; m++)
      begin
         wr(6'h30, 8'(m));
         shed_level <= 1'b1;
         cyc(8);
         chk({4'h0, port_power_en}, 8'h0a);
         chk({4'h0, probe_allow}, 8'h0a);
         rdc(6'h10, 8'haa);
         rdc(6'h00, 8'h80);
         rdc(6'h0a, 8'h02);
         rdc(6'h0b, 8'h02);
         rdc(6'h00, 8'h00);
         shed_level <= 1'b0;
         cyc(8);
         rdc(6'h0a, 8'h00);
         if (m == 0)
         begin
            rdc(6'h14, 8'h0a);
            wr(6'h14, 8'h0f);
            cyc(4);
         end
         chk({4'h0, port_power_en}, 8'h0f);
      end
      for (int i = 0; i < 4; i++) pr[i] = 3'(xs());
      pr[0] = 3'h0;
      pr[3] = 3'h7;
      wr(6'h27, {1'b0, pr[1], 1'b0, pr[0]});
      wr(6'h28, {1'b0, pr[3], 1'b0, pr[2]});
      wr(6'h17, 8'h10);
      chk({7'h0, multi_bit_sel}, 8'h01);
      cyc(60);
      for (int w = 0; w < 2; w++)
      begin
         shed_level <= 1'b1;
         cyc(w == 0 ? 100 : 3300);
         shed_level <= 1'b0;
         cyc(300);
         rdc(6'h0a, 8'h00);
         chk({4'h0, port_power_en}, 8'h0f);
      end
      wr(6'h17, 8'h00);
      peer_multi_bit <= 1'b1;
      multi_mode <= 1'b1;
      cyc(60);
      frame(3'h7);
      peer_multi_bit <= 1'b0;
      wr(6'h17, 8'h10);
      cyc(60);
      for (int k = 0; k < 4; k++)
      begin
         p = xs();
         power_request <= p[3:0] | 4'h1;
         cyc(4);
         frame(k == 0 ? 3'h0 : p[6:4]);
      end
      finish_test();
   end
endmodule
